// ### tw_pkg.sv
// constants shared by the two-wire register slice
package tw_pkg;

  // ==========================================================
  // register addresses
  localparam logic [31:0] TW_ADDR_STATUS = 32'hFFFAC020;
  localparam logic [31:0] TW_ADDR_IER = 32'hFFFAC024;
  localparam logic [31:0] TW_ADDR_IDR = 32'hFFFAC028;
  localparam logic [31:0] TW_ADDR_IMR = 32'hFFFAC02C;
  localparam logic [31:0] TW_ADDR_RHR = 32'hFFFAC030;
  localparam logic [31:0] TW_ADDR_THR = 32'hFFFAC034;

  // ==========================================================
  // event bit positions, shared by status and mask
  localparam int TW_IRQ_W = 12;
  localparam int TW_BIT_TRANSFER_COMPLETE = 0;
  localparam int TW_BIT_RX_READY = 1;
  localparam int TW_BIT_TX_READY = 2;
  localparam int TW_BIT_SLAVE_ACCESS = 4;
  localparam int TW_BIT_GENERAL_CALL = 5;
  localparam int TW_BIT_OVERRUN = 6;
  localparam int TW_BIT_NOT_ACK_FLAG = 8;
  localparam int TW_BIT_ARBITRATION_LOST = 9;
  localparam int TW_BIT_CLKWAIT = 10;
  localparam int TW_BIT_END_OF_SLAVE_ACCESS = 11;
  localparam logic [11:0] TW_USED_BITS = 12'hF77;
  localparam logic [11:0] TW_STICKY_BITS = 12'hB61;

  // ==========================================================
  // widths and reset values
  localparam int TW_BYTE_W = 8;
  localparam logic [11:0] TW_MASK_RST = 12'h000;
  localparam logic [11:0] TW_STICKY_RST = 12'h000;
  localparam logic [31:0] TW_RDATA_RST = 32'h00000000;
  localparam logic [7:0] TW_BYTE_RST = 8'h00;

endpackage

// ### tw_hold_byte.sv
// one-entry byte holding register with occupancy flag
`timescale 1ns/1ns
module tw_hold_byte
  import tw_pkg::*;
#(
  parameter int W = TW_BYTE_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // fill and drain
  input wire logic load,
  input wire logic [W-1:0] loadData,
  input wire logic drop,
  // state
  output logic full,
  output logic [W-1:0] data,
  output logic overrun
);

  // ==========================================================
  // state
  typedef struct packed {
    logic full;
    logic [W-1:0] data;
  } tw_hold_t;

  tw_hold_t st_reg;
  tw_hold_t st_next;

  // load wins over drop so a byte arriving on the drain edge is kept
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      if (load) begin
        st_next.full = 1'b1;
        st_next.data = loadData;
      end else if (drop) begin
        st_next.full = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign full = st_reg.full;
  assign data = st_reg.data;
  assign overrun = ce & load & st_reg.full;

endmodule // tw_hold_byte

// ### tw_irq_mask.sv
// interrupt mask with set and clear write ports and irq gating
`timescale 1ns/1ns
module tw_irq_mask
  import tw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // software writes
  input wire logic enWr,
  input wire logic disWr,
  input wire logic [TW_IRQ_W-1:0] wrBits,
  // events
  input wire logic [TW_IRQ_W-1:0] status,
  output logic [TW_IRQ_W-1:0] mask,
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [TW_IRQ_W-1:0] mask;
  } tw_mask_t;

  tw_mask_t st_reg;
  tw_mask_t st_next;

  // zero bits in a write leave the mask alone
  always_comb begin
    st_next = st_reg;
    if (ce && enWr) begin
      st_next.mask = st_reg.mask | (wrBits & TW_USED_BITS);
    end else if (ce && disWr) begin
      st_next.mask = st_reg.mask & ~(wrBits & TW_USED_BITS);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '{mask: TW_MASK_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign mask = st_reg.mask;
  assign irq = |(status & st_reg.mask);

endmodule // tw_irq_mask

// ### tw_regs.sv
// register slice of the two-wire unit: mask view, receive and transmit holding
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
module tw_regs
  import tw_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  // shift engine, receive side
  input wire logic rxLoad,
  input wire logic [TW_BYTE_W-1:0] rxByte,
  // shift engine, transmit side
  input wire logic txTake,
  output logic [TW_BYTE_W-1:0] txByte,
  output logic txValid,
  // shift engine events and levels
  input wire logic masterMode,
  input wire logic compEvt,
  input wire logic gcallEvt,
  input wire logic nackEvt,
  input wire logic arbEvt,
  input wire logic eosEvt,
  input wire logic slvAccess,
  input wire logic clkWait,
  // interrupt
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] rdData;
    logic [TW_IRQ_W-1:0] sticky;
  } tw_state_t;

  tw_state_t st_reg;
  tw_state_t st_next;

  logic [TW_IRQ_W-1:0] mask;
  logic [TW_IRQ_W-1:0] status;
  logic [TW_BYTE_W-1:0] received_byte;
  logic rxFull;
  logic txFull;
  logic rxOverrun;
  logic hitStatus;
  logic hitRhr;
  logic hitImr;
  logic thrWr;
  logic ierWr;
  logic idrWr;

  // ==========================================================
  // decode
  assign hitStatus = (addr == ADDR_W'(TW_ADDR_STATUS));
  assign hitRhr = (addr == ADDR_W'(TW_ADDR_RHR));
  assign hitImr = (addr == ADDR_W'(TW_ADDR_IMR));
  assign thrWr = wrStb & (addr == ADDR_W'(TW_ADDR_THR));
  assign ierWr = wrStb & (addr == ADDR_W'(TW_ADDR_IER));
  assign idrWr = wrStb & (addr == ADDR_W'(TW_ADDR_IDR));

  // ==========================================================
  // holding registers
  tw_hold_byte #(
    .W(TW_BYTE_W)
  ) u_rx_hold (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .load(rxLoad),
    .loadData(rxByte),
    .drop(rdStb & hitRhr),
    .full(rxFull),
    .data(received_byte),
    .overrun(rxOverrun)
  );

  // a not_ack_flag abandons the held byte so software can refill it
  tw_hold_byte #(
    .W(TW_BYTE_W)
  ) u_tx_hold (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .load(thrWr),
    .loadData(wrData[TW_BYTE_W-1:0]),
    .drop(txTake | nackEvt),
    .full(txFull),
    .data(txByte),
    .overrun()
  );

  assign txValid = txFull;

  // ==========================================================
  // mask and interrupt
  tw_irq_mask u_mask (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .enWr(ierWr),
    .disWr(idrWr),
    .wrBits(wrData[TW_IRQ_W-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // ==========================================================
  // status view: sticky events merged with live levels
  always_comb begin
    status = st_reg.sticky & TW_STICKY_BITS;
    status[TW_BIT_RX_READY] = rxFull;
    status[TW_BIT_TX_READY] = ~txFull;
    status[TW_BIT_SLAVE_ACCESS] = slvAccess;
    status[TW_BIT_CLKWAIT] = clkWait;
  end

  // ==========================================================
  // next state
  always_comb begin
    logic [TW_IRQ_W-1:0] evtSet;
    evtSet = '0;
    st_next = st_reg;
    evtSet[TW_BIT_TRANSFER_COMPLETE] = compEvt;
    evtSet[TW_BIT_GENERAL_CALL] = gcallEvt;
    evtSet[TW_BIT_OVERRUN] = rxOverrun & masterMode;
    evtSet[TW_BIT_NOT_ACK_FLAG] = nackEvt;
    evtSet[TW_BIT_ARBITRATION_LOST] = arbEvt;
    evtSet[TW_BIT_END_OF_SLAVE_ACCESS] = eosEvt;
    if (ce) begin
      // set wins over the read that clears, so no event is lost
      if (rdStb && hitStatus) begin
        st_next.sticky = evtSet & TW_STICKY_BITS;
      end else begin
        st_next.sticky = st_reg.sticky | (evtSet & TW_STICKY_BITS);
      end
      st_next.rdData = TW_RDATA_RST;
      if (rdStb) begin
        if (hitStatus) begin
          st_next.rdData = {20'h00000, status};
        end else if (hitImr) begin
          st_next.rdData = {20'h00000, mask};
        end else if (hitRhr) begin
          st_next.rdData = {24'h000000, received_byte};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '{rdData: TW_RDATA_RST, sticky: TW_STICKY_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdData = st_reg.rdData;

  // ==========================================================
  // checks
  property p_mask_view;
    @(posedge clk_sys) disable iff (rst)
    ce && rdStb && hitImr |=> rdData[TW_IRQ_W-1:0] == $past(mask);
  endproperty
  a_mask_view: assert property (p_mask_view) else $error("mask view read wrong");

  property p_mask_unused;
    @(posedge clk_sys) disable iff (rst)
    ce && rdStb && hitImr |=> rdData[31:12] == 20'h00000 && !rdData[3] && !rdData[7];
  endproperty
  a_mask_unused: assert property (p_mask_unused) else $error("unused mask bits set");

  property p_rx_byte;
    @(posedge clk_sys) disable iff (rst)
    ce && rxLoad ##1 ce && rdStb && hitRhr |=> rdData == {24'h000000, $past(rxByte, 2)};
  endproperty
  a_rx_byte: assert property (p_rx_byte) else $error("received byte lost");

  property p_tx_byte;
    @(posedge clk_sys) disable iff (rst)
    ce && thrWr |=> txValid && txByte == $past(wrData[7:0]);
  endproperty
  a_tx_byte: assert property (p_tx_byte) else $error("transmit byte not held");

  property p_mask_en;
    @(posedge clk_sys) disable iff (rst)
    ce && ierWr |=> (mask & $past(wrData[11:0] & TW_USED_BITS)) == $past(wrData[11:0] & TW_USED_BITS);
  endproperty
  a_mask_en: assert property (p_mask_en) else $error("enable did not set mask");

  property p_mask_dis;
    @(posedge clk_sys) disable iff (rst)
    ce && idrWr |=> (mask & $past(wrData[11:0])) == 12'h000 &&
      ((mask ^ $past(mask)) & ~$past(wrData[11:0])) == 12'h000;
  endproperty
  a_mask_dis: assert property (p_mask_dis) else $error("disable did not clear mask");

  property p_rx_ready;
    @(posedge clk_sys) disable iff (rst)
    ce && rxLoad |=> status[TW_BIT_RX_READY];
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("rx ready flag not set");

  property p_rx_clear;
    @(posedge clk_sys) disable iff (rst)
    ce && rdStb && hitRhr && !rxLoad |=> !status[TW_BIT_RX_READY];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx ready flag not cleared");

  property p_tx_ready;
    @(posedge clk_sys) disable iff (rst)
    ce && thrWr |=> !status[TW_BIT_TX_READY];
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx ready flag not cleared");

  property p_tx_refill;
    @(posedge clk_sys) disable iff (rst)
    ce && (txTake || nackEvt) && !thrWr |=> status[TW_BIT_TX_READY];
  endproperty
  a_tx_refill: assert property (p_tx_refill) else $error("tx ready flag not set");

  property p_overrun;
    @(posedge clk_sys) disable iff (rst)
    ce && rxLoad && rxFull && masterMode |=> status[TW_BIT_OVERRUN] && rxFull;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_irq;
    @(posedge clk_sys) disable iff (rst)
    ce && rxLoad && mask[TW_BIT_RX_READY] && !(ierWr || idrWr) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_off;
    @(posedge clk_sys) disable iff (rst)
    ce && idrWr && (wrData[TW_IRQ_W-1:0] | ~TW_USED_BITS) == 12'hFFF |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt stays high with mask cleared");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (rst)
    ce && !rdStb |=> rdData == TW_RDATA_RST;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data stands too long");

  property p_status_rd;
    @(posedge clk_sys) disable iff (rst)
    ce && rdStb && hitStatus |=> rdData == {20'h00000, $past(status)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_sticky_clr;
    @(posedge clk_sys) disable iff (rst)
    ce && rdStb && hitStatus && !compEvt && !gcallEvt && !nackEvt && !arbEvt && !eosEvt &&
      !(rxOverrun && masterMode) |=> (status & TW_STICKY_BITS) == 12'h000;
  endproperty
  a_sticky_clr: assert property (p_sticky_clr) else $error("status read did not clear events");

  property p_not_ack_flag_evt;
    @(posedge clk_sys) disable iff (rst)
    ce && nackEvt && !thrWr |=> status[TW_BIT_NOT_ACK_FLAG] && status[TW_BIT_TX_READY];
  endproperty
  a_not_ack_flag_evt: assert property (p_not_ack_flag_evt) else $error("not_ack_flag did not free transmit holding");

  property p_no_ovr_slave;
    @(posedge clk_sys) disable iff (rst)
    ce && rxLoad && !masterMode && !status[TW_BIT_OVERRUN] |=> !status[TW_BIT_OVERRUN];
  endproperty
  a_no_ovr_slave: assert property (p_no_ovr_slave) else $error("overrun outside master operation");

  property p_freeze;
    @(posedge clk_sys) disable iff (rst)
    !ce |=> $stable(st_reg) && $stable(mask) && $stable(txValid) && $stable(rxFull);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  c_rx_read: cover property (@(posedge clk_sys) disable iff (rst) rxLoad ##[1:4] rdStb && hitRhr);
  c_tx_take: cover property (@(posedge clk_sys) disable iff (rst) thrWr ##[1:8] txTake);
  c_ovr: cover property (@(posedge clk_sys) disable iff (rst) rxOverrun && masterMode);
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
  c_ce_low: cover property (@(posedge clk_sys) disable iff (rst) !ce ##1 ce);

endmodule // tw_regs

// ### tw_engine_model.sv
// stand-in for the shift engine on the far side of the register slice
`timescale 1ns/1ns
module tw_engine_model
  import tw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // transmit side
  input wire logic [TW_BYTE_W-1:0] txByte,
  input wire logic txValid,
  input wire logic [7:0] takeDelay,
  output logic txTake,
  // receive side and events
  output logic rxLoad,
  output logic [TW_BYTE_W-1:0] rxByte,
  output logic [4:0] evt
);
  logic [7:0] waitCnt;
  logic [TW_BYTE_W-1:0] taken[$];

  initial begin
    rxLoad = 1'b0;
    rxByte = 8'h00;
    evt = 5'h00;
  end

  // ==========================================================
  // receive: byte valid for one cycle, then the lines show its inverse
  task automatic send_rx(input logic [7:0] b);
    @(posedge clk_sys);
    rxLoad <= 1'b1;
    rxByte <= b;
    @(posedge clk_sys);
    rxLoad <= 1'b0;
    rxByte <= ~b;
  endtask

  task automatic pulse_evt(input int i);
    @(posedge clk_sys);
    evt[i] <= 1'b1;
    @(posedge clk_sys);
    evt <= 5'h00;
  endtask

  // ==========================================================
  // transmit: a stall of takeDelay cycles models a slow shifter
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      waitCnt <= 8'h00;
      txTake <= 1'b0;
    end else if (txValid && !txTake && waitCnt >= takeDelay) begin
      txTake <= 1'b1;
      taken.push_back(txByte);
      waitCnt <= 8'h00;
    end else begin
      txTake <= 1'b0;
      waitCnt <= txValid ? waitCnt + 8'h01 : 8'h00;
    end
  end
endmodule // tw_engine_model

// ### test_two_wire_mask_and_data_regs.sv
// self-checking bench of the two-wire register slice
`timescale 1ns/1ns
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errCount++; $display("mismatch at %0t: %h not %h", $time, a, e); end end
module test_two_wire_mask_and_data_regs
  import tw_pkg::*;
();
  typedef struct {logic [31:0] port; logic [31:0] val; logic [31:0] mask;} tw_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce, wrStb, rdStb, masterMode, slvAccess, clkWait;
  logic [31:0] addr, wrData;
  logic [31:0] rdData, d;
  logic [7:0] txByte, rxByte;
  logic [7:0] takeDelay;
  logic txValid, txTake, rxLoad, irq;
  logic [4:0] evt;
  int errCount = 0;
  int nCompared = 0;
  int evtPos[5] = '{0, 5, 8, 9, 11};
  int bitPos[10] = '{0, 1, 2, 4, 5, 6, 8, 9, 10, 11};
  tw_row_t rows[7] = '{
    '{TW_ADDR_IER, 32'hFFFFFFFF, 32'h00000F77},
    '{TW_ADDR_IDR, 32'h00000001, 32'h00000F76},
    '{TW_ADDR_IER, 32'h00000000, 32'h00000F76},
    '{TW_ADDR_IDR, 32'h00000000, 32'h00000F76},
    '{TW_ADDR_IDR, 32'h00000F00, 32'h00000076},
    '{TW_ADDR_IER, 32'h00000100, 32'h00000176},
    '{TW_ADDR_IDR, 32'hFFFFFFFF, 32'h00000000}};

  always #4 clk_sys = ~clk_sys;

  tw_regs dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .rxLoad(rxLoad), .rxByte(rxByte), .txTake(txTake), .txByte(txByte), .txValid(txValid),
    .masterMode(masterMode), .compEvt(evt[0]), .gcallEvt(evt[1]), .nackEvt(evt[2]), .arbEvt(evt[3]),
    .eosEvt(evt[4]), .slvAccess(slvAccess), .clkWait(clkWait), .irq(irq));
  tw_engine_model eng (.clk_sys(clk_sys), .rst(rst), .txByte(txByte), .txValid(txValid), .takeDelay(takeDelay),
    .txTake(txTake), .rxLoad(rxLoad), .rxByte(rxByte), .evt(evt));

  // ==========================================================
  // register port
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wrStb <= 1'b1;
    addr <= a;
    wrData <= v;
    @(posedge clk_sys);
    wrStb <= 1'b0;
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    rdStb <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rdStb <= 1'b0;
    #1 d = rdData;
    `CHK(d, e)
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400000;
    errCount++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    ce <= 1'b1;
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    masterMode <= 1'b0;
    slvAccess <= 1'b0;
    clkWait <= 1'b0;
    addr <= 32'h00000000;
    wrData <= 32'h00000000;
    takeDelay <= 8'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1 `CHK(irq, 1'b0)
    `CHK(txValid, 1'b0)
    chk_rd(TW_ADDR_IMR, 32'h0);
    chk_rd(TW_ADDR_STATUS, 32'h4);
    foreach (rows[i]) begin
      wr(rows[i].port, rows[i].val);
      chk_rd(TW_ADDR_IMR, rows[i].mask);
    end
    foreach (bitPos[i]) begin
      wr(TW_ADDR_IER, 32'h1 << bitPos[i]);
      chk_rd(TW_ADDR_IMR, 32'h1 << bitPos[i]);
      wr(TW_ADDR_IDR, 32'h1 << bitPos[i]);
    end
    $display("test mask ports done");
    wr(TW_ADDR_IER, 32'h00000B21);
    foreach (evtPos[i]) begin
      eng.pulse_evt(i);
      #1 `CHK(irq, 1'b1)
      chk_rd(TW_ADDR_STATUS, 32'h4 | (32'h1 << evtPos[i]));
      `CHK(irq, 1'b0)
    end
    wr(TW_ADDR_IDR, 32'h00000B21);
    eng.pulse_evt(0);
    #1 `CHK(irq, 1'b0)
    chk_rd(TW_ADDR_STATUS, 32'h5);
    @(posedge clk_sys);
    slvAccess <= 1'b1;
    clkWait <= 1'b1;
    chk_rd(TW_ADDR_STATUS, 32'h414);
    slvAccess <= 1'b0;
    clkWait <= 1'b0;
    $display("test events done");
    wr(TW_ADDR_IER, 32'h2);
    eng.send_rx(8'hA5);
    #1 `CHK(irq, 1'b1)
    chk_rd(TW_ADDR_STATUS, 32'h6);
    chk_rd(TW_ADDR_RHR, 32'hA5);
    `CHK(irq, 1'b0)
    chk_rd(TW_ADDR_STATUS, 32'h4);
    // read strobe in the cycle right after the load
    fork
      eng.send_rx(8'h3C);
      begin
        @(posedge clk_sys);
        chk_rd(TW_ADDR_RHR, 32'h3C);
      end
    join
    wr(TW_ADDR_IDR, 32'h2);
    @(posedge clk_sys);
    masterMode <= 1'b1;
    eng.send_rx(8'h11);
    eng.send_rx(8'h22);
    chk_rd(TW_ADDR_STATUS, 32'h46);
    chk_rd(TW_ADDR_RHR, 32'h22);
    @(posedge clk_sys);
    masterMode <= 1'b0;
    eng.send_rx(8'h33);
    eng.send_rx(8'h44);
    chk_rd(TW_ADDR_STATUS, 32'h6);
    chk_rd(TW_ADDR_RHR, 32'h44);
    $display("test receive done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      takeDelay <= 8'(i * 6);
      wr(TW_ADDR_THR, 32'hABCDEFC3 + i);
      #1 `CHK(txValid, 1'b1)
      `CHK(txByte, 8'hC3 + i)
      for (int k = 0; k < 300 && txValid !== 1'b0; k++) @(posedge clk_sys);
      if (txValid !== 1'b0) begin
        errCount++;
        stop_test();
      end
      d = eng.taken.pop_front();
      `CHK(d, 8'hC3 + i)
      chk_rd(TW_ADDR_STATUS, 32'h4);
    end
    @(posedge clk_sys);
    takeDelay <= 8'hC8;
    wr(TW_ADDR_THR, 32'h5A);
    chk_rd(TW_ADDR_STATUS, 32'h0);
    eng.pulse_evt(2);
    #1 `CHK(txValid, 1'b0)
    chk_rd(TW_ADDR_STATUS, 32'h104);
    $display("test transmit done");
    // unmapped place and read-only or write-only views refuse
    wr(32'hFFFAC040, 32'hFFFFFFFF);
    wr(TW_ADDR_IMR, 32'hFFFFFFFF);
    chk_rd(TW_ADDR_IMR, 32'h0);
    chk_rd(32'hFFFAC040, 32'h0);
    chk_rd(TW_ADDR_THR, 32'h0);
    // clock enable low: strobes and engine pulses are ignored
    wr(TW_ADDR_IER, 32'h2);
    @(posedge clk_sys);
    ce <= 1'b0;
    chk_rd(TW_ADDR_IMR, 32'h0);
    wr(TW_ADDR_IDR, 32'h2);
    eng.send_rx(8'h5A);
    #1 `CHK(irq, 1'b0)
    @(posedge clk_sys);
    ce <= 1'b1;
    chk_rd(TW_ADDR_IMR, 32'h2);
    chk_rd(TW_ADDR_STATUS, 32'h4);
    wr(TW_ADDR_IER, 32'h4);
    #1 `CHK(irq, 1'b1)
    wr(TW_ADDR_IDR, 32'h6);
    $display("test clock enable done");
    wr(TW_ADDR_IER, 32'hFFFFFFFF);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    chk_rd(TW_ADDR_IMR, 32'h0);
    `CHK(irq, 1'b0)
    $display("test refusals and reset done");
    stop_test();
  end
endmodule // test_two_wire_mask_and_data_regs
